// >>> sdwtp_pkg.sv
package sdwtp_pkg;

  // ----------------------------------------
  // widths
  // ----------------------------------------
  localparam int unsigned ADDR_W = 13;
  localparam int unsigned COL_W  = 9;
  localparam int unsigned DQ_W   = 16;
  localparam int unsigned SCOPE_BIT = 10; // precharge_scope_line position in addr

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int unsigned CLK_PERIOD_PS = 25000; // 40 MHz
  localparam int unsigned TWR_NS = 15;           // write_recovery_time default
  localparam int unsigned TRP_NS = 20;           // precharge_period default
  localparam logic [3:0] TWR_CYC = 4'((TWR_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [3:0] TRP_CYC = 4'((TRP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [3:0] MIN_CYC = 4'h1;

  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [7:0] REG_CFG  = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam int unsigned CFG_BL_LSB  = 0;  // 3-bit burst length code
  localparam int unsigned CFG_WBM_BIT = 3;  // write_burst_mode_bit
  localparam int unsigned CFG_CL_LSB  = 4;  // 2-bit cas_latency
  localparam int unsigned CFG_TWR_LSB = 8;  // 4-bit recovery cycles
  localparam int unsigned CFG_TRP_LSB = 12; // 4-bit precharge cycles
  localparam int unsigned STAT_ERR_BIT = 8;
  localparam int unsigned STAT_WB_BIT  = 9;
  localparam int unsigned STAT_RB_BIT  = 10;
  localparam logic [2:0] BL_CONT = 3'h7;
  localparam logic [2:0] BL_RST  = 3'h2;
  localparam logic [1:0] CL_RST  = 2'h2;
  localparam logic [31:0] CFG_RST = {16'h0000, TRP_CYC, TWR_CYC, 2'h0, CL_RST, 1'b0, BL_RST};

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum {CMD_NOP, CMD_ACT, CMD_RD, CMD_WR, CMD_PRE, CMD_BST, CMD_OTHER} sdwtp_cmd_t;
  typedef enum logic [1:0] {BK_IDLE, BK_ACTIVE, BK_RECOV, BK_PRECH} sdwtp_bank_t;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // command from the four control pins
  function automatic sdwtp_cmd_t decode(input logic cs_n, ras_n, cas_n, we_n);
    if (cs_n) return CMD_NOP;
    case ({ras_n, cas_n, we_n})
      3'h3:    return CMD_ACT;
      3'h5:    return CMD_RD;
      3'h4:    return CMD_WR;
      3'h2:    return CMD_PRE;
      3'h6:    return CMD_BST;
      3'h7:    return CMD_NOP;
      default: return CMD_OTHER;
    endcase
  endfunction

  // beats in a burst; continuous reports a full page
  function automatic logic [9:0] burst_len(input logic [2:0] code);
    case (code)
      3'h0:    return 10'h001;
      3'h1:    return 10'h002;
      3'h2:    return 10'h004;
      3'h3:    return 10'h008;
      default: return 10'h200;
    endcase
  endfunction

  // sequential column step, wrapping inside the burst block or the page
  function automatic logic [COL_W-1:0] next_col(input logic [COL_W-1:0] col,
                                                input logic [2:0] code);
    logic [COL_W-1:0] m;
    m = COL_W'(burst_len(code) - 10'h001);
    return (col & ~m) | ((col + 9'h001) & m);
  endfunction

  // zero cycles would skip a state; hold at least one clock
  function automatic logic [3:0] at_least_one(input logic [3:0] v);
    return (v == 4'h0) ? MIN_CYC : v;
  endfunction

endpackage

// >>> sdwtp_bank.sv
`timescale 1ns/1ps
module sdwtp_bank (
  input  wire logic             ref_clk, // clock
  input  wire logic             resetn,  // async reset, low
  input  wire logic             act,     // open a row
  input  wire logic             pre,     // start precharge now
  input  wire logic             rec,     // start recovery, then precharge
  input  wire logic [3:0]       twr_cyc, // recovery cycles
  input  wire logic [3:0]       trp_cyc, // precharge cycles
  output sdwtp_pkg::sdwtp_bank_t st      // bank state
);

  sdwtp_pkg::sdwtp_bank_t st_r;
  logic [3:0]             cnt_r;

  assign st = st_r;

  // ----------------------------------------
  // bank state and timers
  // ----------------------------------------
  // per-bank timers
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      st_r  <= sdwtp_pkg::BK_IDLE;
      cnt_r <= 4'h0;
    end else begin
      case (st_r)
        sdwtp_pkg::BK_IDLE: begin
          if (act) st_r <= sdwtp_pkg::BK_ACTIVE;
        end
        sdwtp_pkg::BK_ACTIVE: begin
          if (pre) begin
            st_r  <= sdwtp_pkg::BK_PRECH;
            cnt_r <= sdwtp_pkg::at_least_one(trp_cyc);
          end else if (rec) begin
            st_r  <= sdwtp_pkg::BK_RECOV;
            cnt_r <= sdwtp_pkg::at_least_one(twr_cyc);
          end
        end
        sdwtp_pkg::BK_RECOV: begin
          if (cnt_r <= 4'h1) begin
            st_r  <= sdwtp_pkg::BK_PRECH;
            cnt_r <= sdwtp_pkg::at_least_one(trp_cyc);
          end else begin
            cnt_r <= cnt_r - 4'h1;
          end
        end
        sdwtp_pkg::BK_PRECH: begin
          if (cnt_r <= 4'h1) st_r <= sdwtp_pkg::BK_IDLE;
          else cnt_r <= cnt_r - 4'h1;
        end
        default: st_r <= sdwtp_pkg::BK_IDLE;
      endcase
    end
  end

endmodule

// >>> sdwtp_wb_regs.sv
`timescale 1ns/1ps
module sdwtp_wb_regs (
  input  wire logic        ref_clk,   // clock
  input  wire logic        resetn,    // async reset, low
  input  wire logic        wb_cyc_i,  // cycle
  input  wire logic        wb_stb_i,  // strobe
  input  wire logic        wb_we_i,   // write
  input  wire logic [7:0]  wb_adr_i,  // byte address
  input  wire logic [3:0]  wb_sel_i,  // byte enables
  input  wire logic [31:0] wb_dat_i,  // write data
  output logic      [31:0] wb_dat_o,  // read data
  output logic             wb_ack_o,  // acknowledge
  input  wire logic [31:0] stat_i,    // live status
  output logic      [31:0] cfg_o,     // configuration
  output logic             err_clr_o  // clear error, one pulse
);

  logic        ack_r;
  logic [31:0] dat_r;
  logic [31:0] cfg_r;
  logic        clr_r;
  logic        take;

  assign wb_ack_o  = ack_r;
  assign wb_dat_o  = dat_r;
  assign cfg_o     = cfg_r;
  assign err_clr_o = clr_r;
  // one wait state; ack drops the cycle after it was given
  assign take = wb_cyc_i && wb_stb_i && !ack_r;

  // ----------------------------------------
  // handshake and read data
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0000_0000;
    end else begin
      ack_r <= take;
      if (take && !wb_we_i) begin
        case (wb_adr_i)
          sdwtp_pkg::REG_CFG:  dat_r <= cfg_r;
          sdwtp_pkg::REG_STAT: dat_r <= stat_i;
          default:             dat_r <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ----------------------------------------
  // configuration writes, byte lanes
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cfg_r <= sdwtp_pkg::CFG_RST;
    end else if (take && wb_we_i && wb_adr_i == sdwtp_pkg::REG_CFG) begin
      for (int i = 0; i < 2; i++) begin
        if (wb_sel_i[i]) cfg_r[i*8 +: 8] <= wb_dat_i[i*8 +: 8];
      end
    end
  end

  // write one to the error bit clears it
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) clr_r <= 1'b0;
    else clr_r <= take && wb_we_i && wb_adr_i == sdwtp_pkg::REG_STAT && wb_sel_i[1]
                  && wb_dat_i[sdwtp_pkg::STAT_ERR_BIT];
  end

endmodule

// >>> sdwtp_core.sv
// Overview of operation
// - read ends write burst, later data ignored
// - precharge ends write only without auto-precharge
// - precharge may end continuous write burst
// - auto-precharge recovery at least one clock
// - no command to bank while precharging
// - burst terminate drops its own data word
// - single write mode bit forces one column
// - precharge closes one bank or all
// - precharged bank idle, needs activate first
// - scope line on access enables auto-precharge
// - continuous length beats single mode, no precharge
// - auto-precharge choice held per command only
// - auto-precharge busy time as explicit precharge
// - read to other bank ends read, precharges
// - write to other bank ends read, precharges
// - read to other bank starts write recovery
// - write to other bank starts write recovery
// - last old-bank word precedes interrupting write
// - data taken with command then each edge
`timescale 1ns/1ps
module sdwtp_core (
  input  wire logic        ref_clk,          // 40 MHz clock
  input  wire logic        resetn,           // async reset, low
  input  wire logic        cs_n,             // chip select, low
  input  wire logic        ras_n,            // row strobe, low
  input  wire logic        cas_n,            // column strobe, low
  input  wire logic        we_n,             // write enable, low
  input  wire logic        bank_select_low,  // bank bit 0
  input  wire logic        bank_select_high, // bank bit 1
  input  wire logic [12:0] addr,             // row / column address
  input  wire logic        dqm,              // input data mask, high masks
  input  wire logic [15:0] dq_in,            // write data
  input  wire logic        wb_cyc_i,         // wishbone cycle
  input  wire logic        wb_stb_i,         // wishbone strobe
  input  wire logic        wb_we_i,          // wishbone write
  input  wire logic [7:0]  wb_adr_i,         // wishbone address
  input  wire logic [3:0]  wb_sel_i,         // wishbone byte enables
  input  wire logic [31:0] wb_dat_i,         // wishbone write data
  output logic      [31:0] wb_dat_o,         // wishbone read data
  output logic             wb_ack_o,         // wishbone acknowledge
  output logic             wr_en,            // array write strobe
  output logic      [1:0]  wr_bank,          // array write bank
  output logic      [12:0] wr_row,           // array write row
  output logic      [8:0]  wr_col,           // array write column
  output logic      [15:0] wr_data           // array write data
);

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  sdwtp_pkg::sdwtp_bank_t bank_st [4];
  sdwtp_pkg::sdwtp_cmd_t  cmd;
  logic [31:0] cfg;
  logic [31:0] stat;
  logic        err_clr;
  logic [2:0]  bl_code;
  logic        wbm;
  logic [3:0]  twr_cyc;
  logic [3:0]  trp_cyc;
  logic [1:0]  bk;
  logic        scope;
  logic        cont;
  logic [9:0]  wlen;
  logic [9:0]  rlen;
  logic [12:0] row_r [4];
  logic        wb_act_r, wb_ap_r, wb_cont_r;
  logic [1:0]  wb_bank_r;
  logic [8:0]  wb_col_r;
  logic [9:0]  wb_left_r;
  logic        rb_act_r, rb_ap_r, rb_cont_r;
  logic [1:0]  rb_bank_r;
  logic [9:0]  rb_left_r;
  logic        err_r;
  logic        wr_en_r;
  logic [1:0]  wr_bank_r;
  logic [12:0] wr_row_r;
  logic [8:0]  wr_col_r;
  logic [15:0] wr_data_r;
  logic        ok_act, ok_rd, ok_wr, ok_pre, is_bst, bad;
  logic        w_stop, w_beat, r_stop;
  logic [3:0]  act_v, pre_v, rec_v, busy_v;

  assign bl_code = cfg[sdwtp_pkg::CFG_BL_LSB +: 3];
  assign wbm     = cfg[sdwtp_pkg::CFG_WBM_BIT];
  assign twr_cyc = cfg[sdwtp_pkg::CFG_TWR_LSB +: 4];
  assign trp_cyc = cfg[sdwtp_pkg::CFG_TRP_LSB +: 4];
  assign cmd     = sdwtp_pkg::decode(cs_n, ras_n, cas_n, we_n);
  assign bk      = {bank_select_high, bank_select_low};
  assign scope   = addr[sdwtp_pkg::SCOPE_BIT];
  assign cont    = bl_code == sdwtp_pkg::BL_CONT;
  assign wlen    = (wbm && !cont) ? 10'h001 : sdwtp_pkg::burst_len(bl_code);
  assign rlen    = sdwtp_pkg::burst_len(bl_code);
  assign wr_en   = wr_en_r;
  assign wr_bank = wr_bank_r;
  assign wr_row  = wr_row_r;
  assign wr_col  = wr_col_r;
  assign wr_data = wr_data_r;

  // ----------------------------------------
  // register slave and banks
  // ----------------------------------------
  sdwtp_wb_regs u_regs (
    .ref_clk   (ref_clk),
    .resetn    (resetn),
    .wb_cyc_i  (wb_cyc_i),
    .wb_stb_i  (wb_stb_i),
    .wb_we_i   (wb_we_i),
    .wb_adr_i  (wb_adr_i),
    .wb_sel_i  (wb_sel_i),
    .wb_dat_i  (wb_dat_i),
    .wb_dat_o  (wb_dat_o),
    .wb_ack_o  (wb_ack_o),
    .stat_i    (stat),
    .cfg_o     (cfg),
    .err_clr_o (err_clr)
  );

  for (genvar g = 0; g < 4; g++) begin : g_bank
    sdwtp_bank u_bank (
      .ref_clk (ref_clk),
      .resetn  (resetn),
      .act     (act_v[g]),
      .pre     (pre_v[g]),
      .rec     (rec_v[g]),
      .twr_cyc (twr_cyc),
      .trp_cyc (trp_cyc),
      .st      (bank_st[g])
    );
    assign busy_v[g] = bank_st[g] == sdwtp_pkg::BK_RECOV || bank_st[g] == sdwtp_pkg::BK_PRECH;
  end

  assign stat = {21'h0, rb_act_r, wb_act_r, err_r, bank_st[3], bank_st[2], bank_st[1],
                 bank_st[0]};

  // ----------------------------------------
  // command legality
  // ----------------------------------------
  always_comb begin
    ok_act = cmd == sdwtp_pkg::CMD_ACT && bank_st[bk] == sdwtp_pkg::BK_IDLE;
    ok_rd  = cmd == sdwtp_pkg::CMD_RD && bank_st[bk] == sdwtp_pkg::BK_ACTIVE;
    ok_wr  = cmd == sdwtp_pkg::CMD_WR && bank_st[bk] == sdwtp_pkg::BK_ACTIVE;
    ok_pre = cmd == sdwtp_pkg::CMD_PRE && (scope ? busy_v == 4'h0 : !busy_v[bk]);
    // no precharge into an auto-precharge burst
    if (ok_pre && wb_act_r && wb_ap_r && (scope || wb_bank_r == bk)) ok_pre = 1'b0;
    if (ok_pre && rb_act_r && rb_ap_r && (scope || rb_bank_r == bk)) ok_pre = 1'b0;
    is_bst = cmd == sdwtp_pkg::CMD_BST;
    bad    = (cmd == sdwtp_pkg::CMD_ACT && !ok_act) || (cmd == sdwtp_pkg::CMD_RD && !ok_rd)
             || (cmd == sdwtp_pkg::CMD_WR && !ok_wr) || (cmd == sdwtp_pkg::CMD_PRE && !ok_pre)
             || cmd == sdwtp_pkg::CMD_OTHER;
  end

  // ----------------------------------------
  // burst stop and bank triggers
  // ----------------------------------------
  always_comb begin
    w_stop = ok_rd || is_bst || (ok_pre && (scope || wb_bank_r == bk));
    w_beat = wb_act_r && !w_stop && !ok_wr;
    r_stop = ok_rd || ok_wr || is_bst || (ok_pre && (scope || rb_bank_r == bk));
    act_v = 4'h0;
    pre_v = 4'h0;
    rec_v = 4'h0;
    if (ok_act) act_v[bk] = 1'b1;
    if (ok_pre) begin
      if (scope) pre_v = 4'hf;
      else pre_v[bk] = 1'b1;
    end
    // read with auto-precharge closes at burst end
    if (rb_act_r && rb_ap_r && !r_stop && rb_left_r == 10'h000) pre_v[rb_bank_r] = 1'b1;
    // other-bank access starts read precharge now
    if (rb_act_r && rb_ap_r && (ok_rd || ok_wr) && bk != rb_bank_r) pre_v[rb_bank_r] = 1'b1;
    if (ok_wr && scope && !cont && wlen == 10'h001) rec_v[bk] = 1'b1;
    // recovery after last wanted word, then precharge
    if (w_beat && wb_ap_r && wb_left_r == 10'h001) rec_v[wb_bank_r] = 1'b1;
    if (wb_act_r && wb_ap_r && is_bst) rec_v[wb_bank_r] = 1'b1;
    if (wb_act_r && wb_ap_r && (ok_rd || ok_wr) && bk != wb_bank_r) rec_v[wb_bank_r] = 1'b1;
  end

  // ----------------------------------------
  // row address per bank
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < 4; i++) row_r[i] <= 13'h0000;
    end else if (ok_act) begin
      row_r[bk] <= addr;
    end
  end

  // ----------------------------------------
  // write burst tracking
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      wb_act_r  <= 1'b0;
      wb_ap_r   <= 1'b0;
      wb_cont_r <= 1'b0;
      wb_bank_r <= 2'h0;
      wb_col_r  <= 9'h000;
      wb_left_r <= 10'h000;
    end else if (ok_wr) begin
      wb_act_r  <= cont || wlen != 10'h001;
      // auto-precharge taken from this command only
      wb_ap_r   <= scope && !cont;
      wb_cont_r <= cont;
      wb_bank_r <= bk;
      wb_col_r  <= sdwtp_pkg::next_col(addr[8:0], bl_code);
      wb_left_r <= wlen - 10'h001;
    end else if (wb_act_r) begin
      if (w_stop || (!wb_cont_r && wb_left_r == 10'h001)) wb_act_r <= 1'b0;
      wb_col_r  <= sdwtp_pkg::next_col(wb_col_r, wb_cont_r ? sdwtp_pkg::BL_CONT : bl_code);
      wb_left_r <= wb_left_r - 10'h001;
    end
  end

  // ----------------------------------------
  // read burst tracking for every read; precharges only with auto-precharge
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rb_act_r  <= 1'b0;
      rb_ap_r   <= 1'b0;
      rb_cont_r <= 1'b0;
      rb_bank_r <= 2'h0;
      rb_left_r <= 10'h000;
    end else if (ok_rd) begin
      rb_act_r  <= 1'b1;
      rb_ap_r   <= scope && !cont;
      rb_cont_r <= cont;
      rb_bank_r <= bk;
      rb_left_r <= rlen - 10'h001;
    end else if (rb_act_r) begin
      if (r_stop || (!rb_cont_r && rb_left_r == 10'h000)) rb_act_r <= 1'b0;
      rb_left_r <= rb_left_r - 10'h001;
    end
  end

  // ----------------------------------------
  // array write port
  // ----------------------------------------
  // first word with command, then each edge
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      wr_en_r   <= 1'b0;
      wr_bank_r <= 2'h0;
      wr_row_r  <= 13'h0000;
      wr_col_r  <= 9'h000;
      wr_data_r <= 16'h0000;
    end else begin
      // new write data belongs to the new bank
      wr_en_r   <= (ok_wr || w_beat) && !dqm;
      wr_bank_r <= ok_wr ? bk : wb_bank_r;
      wr_row_r  <= ok_wr ? row_r[bk] : row_r[wb_bank_r];
      wr_col_r  <= ok_wr ? addr[8:0] : wb_col_r;
      wr_data_r <= dq_in;
    end
  end

  // refused command flag; a new refusal beats the clear
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) err_r <= 1'b0;
    else if (bad) err_r <= 1'b1;
    else if (err_clr) err_r <= 1'b0;
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  property p_rd_stops_wr;
    @(posedge ref_clk) disable iff (!resetn) (ok_rd && wb_act_r) |=> !wr_en_r ##1 !wb_act_r;
  endproperty
  a_rd_stops_wr: assert property (p_rd_stops_wr) else $error("write after read");

  property p_bst_drop;
    @(posedge ref_clk) disable iff (!resetn) (is_bst && wb_act_r && !ok_wr) |=> !wr_en_r;
  endproperty
  a_bst_drop: assert property (p_bst_drop) else $error("terminate data stored");

  property p_first_word;
    @(posedge ref_clk) disable iff (!resetn)
      (ok_wr && !dqm) |=> wr_en_r && wr_data_r == $past(dq_in) && wr_bank_r == $past(bk);
  endproperty
  a_first_word: assert property (p_first_word) else $error("first word lost");

  property p_single_write;
    @(posedge ref_clk) disable iff (!resetn) (ok_wr && wbm && !cont) |=> !wb_act_r;
  endproperty
  a_single_write: assert property (p_single_write) else $error("single write burst");

  property p_pre_one;
    @(posedge ref_clk) disable iff (!resetn)
      (ok_pre && !scope && bank_st[bk] == sdwtp_pkg::BK_ACTIVE)
      |=> bank_st[$past(bk)] == sdwtp_pkg::BK_PRECH;
  endproperty
  a_pre_one: assert property (p_pre_one) else $error("bank not precharging");

  property p_pre_all;
    @(posedge ref_clk) disable iff (!resetn)
      (ok_pre && scope) |=> bank_st[0] != sdwtp_pkg::BK_ACTIVE && bank_st[1] !=
      sdwtp_pkg::BK_ACTIVE && bank_st[2] != sdwtp_pkg::BK_ACTIVE && bank_st[3] !=
      sdwtp_pkg::BK_ACTIVE;
  endproperty
  a_pre_all: assert property (p_pre_all) else $error("bank left open");

  property p_busy_refuse;
    @(posedge ref_clk) disable iff (!resetn)
      (cmd != sdwtp_pkg::CMD_NOP && busy_v[bk] && !scope) |-> !ok_act && !ok_rd && !ok_wr;
  endproperty
  a_busy_refuse: assert property (p_busy_refuse) else $error("busy bank accepted");

  property p_cont_no_ap;
    @(posedge ref_clk) disable iff (!resetn) (ok_wr && cont) |=> !wb_ap_r && wb_act_r;
  endproperty
  a_cont_no_ap: assert property (p_cont_no_ap) else $error("continuous auto-precharge");

  property p_wr_intr;
    @(posedge ref_clk) disable iff (!resetn)
      (wb_act_r && wb_ap_r && (ok_rd || ok_wr) && bk != wb_bank_r)
      |=> bank_st[$past(wb_bank_r)] == sdwtp_pkg::BK_RECOV;
  endproperty
  a_wr_intr: assert property (p_wr_intr) else $error("no recovery on interrupt");

  property p_rd_intr;
    @(posedge ref_clk) disable iff (!resetn)
      (rb_act_r && rb_ap_r && ok_rd && bk != rb_bank_r)
      |=> bank_st[$past(rb_bank_r)] == sdwtp_pkg::BK_PRECH;
  endproperty
  a_rd_intr: assert property (p_rd_intr) else $error("no precharge on interrupt");

  sequence s_recov_done;
    ##[1:16] bank_st[0] == sdwtp_pkg::BK_PRECH;
  endsequence
  property p_recov_end;
    @(posedge ref_clk) disable iff (!resetn)
      ($rose(bank_st[0] == sdwtp_pkg::BK_RECOV)) |-> s_recov_done;
  endproperty
  a_recov_end: assert property (p_recov_end) else $error("recovery never ends");

endmodule

// >>> sdwtp_ctl_model.sv
`timescale 1ns/1ps
// controller side: pins follow the bench, a released bus shows a changed word
module sdwtp_ctl_model (
  input  wire logic        ref_clk,          // clock
  input  wire logic [3:0]  c_cmd,            // cs,ras,cas,we
  input  wire logic [14:0] c_adr,            // bank and address
  input  wire logic        c_dqm,            // mask request
  input  wire logic        c_drv,            // data driven
  input  wire logic [15:0] c_dat,            // data word
  output logic             cs_n,             // chip select
  output logic             ras_n,            // row strobe
  output logic             cas_n,            // column strobe
  output logic             we_n,             // write enable
  output logic             bank_select_low,  // bank bit 0
  output logic             bank_select_high, // bank bit 1
  output logic      [12:0] addr,             // address
  output logic             dqm,              // data mask
  output logic      [15:0] dq_in             // write data
);
  logic [15:0] last_r = 16'h0; // last word driven
  // keep the last word so a released bus can differ from it
  always_ff @(posedge ref_clk) if (c_drv) last_r <= c_dat;
  // order of commands set by the bench
  assign {cs_n, ras_n, cas_n, we_n} = c_cmd;
  assign {bank_select_high, bank_select_low, addr} = c_adr;
  assign dqm = c_dqm;
  assign dq_in = c_drv ? c_dat : ~last_r;
endmodule

// >>> sdwtp_core_tb_top.sv
`timescale 1ns/1ps
module sdwtp_core_tb_top;
  logic        ref_clk, resetn, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, wr_en, c_dqm, c_drv;
  logic        cs_n, ras_n, cas_n, we_n, bank_select_low, bank_select_high, dqm;
  logic [3:0]  c_cmd, wb_sel_i;
  logic [14:0] c_adr;
  logic [15:0] c_dat, dq_in, wr_data;
  logic [12:0] addr, wr_row, r[4];
  logic [8:0]  wr_col;
  logic [1:0]  wr_bank;
  logic [7:0]  wb_adr_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd, rnd;
  logic [39:0] exp_q[$];
  int          n_fail, num_checks;
  sdwtp_ctl_model i_sdwtp_ctl_model (.ref_clk, .c_cmd, .c_adr, .c_dqm, .c_drv, .c_dat, .cs_n,
    .ras_n, .cas_n, .we_n, .bank_select_low, .bank_select_high, .addr, .dqm, .dq_in);
  sdwtp_core i_sdwtp_core (.ref_clk, .resetn, .cs_n, .ras_n, .cas_n, .we_n, .bank_select_low,
    .bank_select_high, .addr, .dqm, .dq_in, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .wr_en, .wr_bank, .wr_row, .wr_col, .wr_data);
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction
  // beat i of a sequential burst wraps inside the block selected by m
  function automatic logic [8:0] wcol(input logic [8:0] c, m, input int i);
    return (c & ~m) | (9'(c + i) & m);
  endfunction
  task automatic chk(input logic [39:0] g, e);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic final_report();
    if (n_fail == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // one controller cycle, fresh random data each time
  task automatic cmd(input logic [3:0] k, input logic [14:0] a, input logic m, d);
    @(posedge ref_clk);
    c_cmd <= k;
    c_adr <= a;
    c_dqm <= m;
    c_drv <= d;
    c_dat <= rnd[15:0];
    rnd = xs(rnd);
  endtask
  task automatic idle(input int n);
    repeat (n) cmd(4'h7, 15'h0, 1'b0, 1'b0);
  endtask
  task automatic act(input logic [1:0] b);
    r[b] = rnd[12:0];
    cmd(4'h3, {b, rnd[12:0]}, 1'b0, 1'b0);
  endtask
  // classic wishbone cycle; the answer time is never assumed
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] v);
    int t = 0;
    @(posedge ref_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= v;
    do begin
      @(posedge ref_clk);
      t++;
    end while (wb_ack_o !== 1'b1 && t < 20);
    if (t >= 20) n_fail++;
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  // n beats sent, first ne expected; column wraps under mask m
  task automatic wrb(input logic [1:0] b, input logic [8:0] c, m, input logic ap,
                     input int n, ne);
    for (int i = 0; i < n; i++) begin
      if (i < ne) exp_q.push_back({b, r[b], wcol(c, m, i), rnd[15:0]});
      cmd(i ? 4'h7 : 4'h4, {b, 2'h0, ap, 1'b0, c}, 1'b0, 1'b1);
    end
  endtask
  // every array write must be the next expected one
  always @(negedge ref_clk) if (resetn === 1'b1 && wr_en !== 1'b0)
    chk({wr_bank, wr_row, wr_col, wr_data}, exp_q.size() ? exp_q.pop_front() : 40'hx);
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  // watchdog, far beyond the hundred-odd cycles needed
  initial begin
    #50000;
    n_fail++;
    final_report();
  end
  initial begin
    {resetn, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, c_adr, c_dqm, c_drv, c_dat} = '0;
    c_cmd = 4'h7;
    wb_sel_i = 4'hf;
    rnd = 32'h0134;
    repeat (4) @(posedge ref_clk);
    resetn <= 1'b1;
    wb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h0000_1122);
    wb(1'b0, 8'h40, 32'h0);
    chk(rd, 32'h0);
    wb(1'b1, 8'h00, 32'h0000_1102);
    act(2'h0);
    wrb(2'h0, rnd[8:0], 9'h3, 1'b1, 4, 4);
    act(2'h0);
    idle(8);
    wb(1'b0, 8'h04, 32'h0);
    chk(rd[8], 1'b1);
    chk(rd[1:0], 2'h0);
    wb(1'b1, 8'h04, 32'h100);
    act(2'h1);
    wrb(2'h1, rnd[8:0], 9'h3, 1'b0, 2, 2);
    cmd(4'h5, 15'h2000, 1'b0, 1'b1);
    cmd(4'h7, 15'h2000, 1'b0, 1'b1);
    wrb(2'h1, rnd[8:0], 9'h3, 1'b0, 1, 1);
    cmd(4'h7, 15'h2000, 1'b1, 1'b1);
    cmd(4'h6, 15'h2000, 1'b0, 1'b1);
    wb(1'b1, 8'h00, 32'h0000_1107);
    act(2'h3);
    wrb(2'h3, rnd[8:0], 9'h1ff, 1'b0, 3, 3);
    cmd(4'h2, 15'h6000, 1'b0, 1'b1);
    idle(6);
    cmd(4'h2, 15'h0400, 1'b0, 1'b0);
    idle(4);
    wb(1'b0, 8'h04, 32'h0);
    chk(rd[7:0], 8'h0);
    wrb(2'h1, 9'h0, 9'h3, 1'b0, 1, 0);
    idle(2);
    wb(1'b0, 8'h04, 32'h0);
    chk(rd[8], 1'b1);
    wb(1'b1, 8'h00, 32'h0000_110a);
    act(2'h2);
    wrb(2'h2, rnd[8:0], 9'h3, 1'b0, 4, 1);
    idle(4);
    chk(exp_q.size(), 0);
    // auto-precharge bursts cut short by accesses to another bank
    wb(1'b1, 8'h00, 32'h0000_1102);
    act(2'h0);
    act(2'h1);
    wrb(2'h0, rnd[8:0], 9'h3, 1'b1, 2, 2);
    wrb(2'h1, rnd[8:0], 9'h3, 1'b1, 4, 4);
    act(2'h0);
    act(2'h3);
    cmd(4'h5, 15'h0400, 1'b0, 1'b0);
    cmd(4'h5, 15'h6000, 1'b0, 1'b0);
    idle(1);
    act(2'h0);
    wrb(2'h0, rnd[8:0], 9'h3, 1'b1, 2, 2);
    cmd(4'h5, 15'h6000, 1'b0, 1'b1);
    idle(4);
    chk(exp_q.size(), 0);
    final_report();
  end
endmodule
